// File: core/spiprm_core.sv
`timescale 1ns/1ps
// Function
// - Master drives the master-to-slave pin; slave treats it as input.
// - Master drives the master-to-slave pin from shift register MSB.
// - Slave-to-master pin is input as master, driven MSB-first as slave.
// - Slave-to-master pin floats when disabled or unselected 4-wire slave.
// - 3-wire slave always drives slave-to-master pin from shift MSB.
// - Serial clock driven only as master; slave takes it from outside.
// - Unselected 4-wire slave ignores serial clock activity.
// - Select mode 00 is 3-wire; slave counts as always selected.
// - Select mode 01 is 4-wire; select pin is input, low selects.
// - Mode 01 master is disabled by a falling select input.
// - Select mode 1x drives select pin with the low mode bit while port enabled.
// - Select unmapped in mode 00, mapped to a pin otherwise.
// - Master-enable makes master; byte write starts transfer if shifter empty.
// - Enabled without master-enable means slave on external clock.
// - Multi-master fault clears master and port enable, sets fault flag.
// - Select mode field resets to 01.
module spiprm_core (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    // Control
    input wire logic i_port_enable_set,
    input wire logic i_port_enable_clr,
    input wire logic i_master_enable_set,
    input wire logic i_master_enable_clr,
    input wire logic i_select_mode_wr,
    input wire logic [1:0] i_select_mode_field,
    input wire logic i_mode_fault_clr,
    output logic o_port_enable_bit,
    output logic o_master_enable_flag,
    output logic [1:0] o_select_mode_field,
    output logic o_mode_fault_flag,
    output logic o_select_mapped,
    output logic o_busy,
    // Transmit stream
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    input wire logic [spiprm_pkg::DATA_W-1:0] i_tx_data,
    // Receive
    output logic o_rx_valid,
    output logic [spiprm_pkg::DATA_W-1:0] o_rx_data,
    // Pins
    input wire logic i_mosi,
    output logic o_mosi,
    output logic o_mosi_oe_n,
    input wire logic i_miso,
    output logic o_miso,
    output logic o_miso_oe_n,
    output logic o_sck,
    output logic o_sck_oe_n,
    input wire logic i_slave_select_n,
    output logic o_slave_select_n,
    output logic o_slave_select_oe_n
);
    import spiprm_pkg::*;

    typedef enum logic [1:0] {SPIPRM_IDLE, SPIPRM_LOW, SPIPRM_HIGH} spiprm_mst_t;

    //------------------------------------------------------------
    // Control state
    //------------------------------------------------------------
    logic port_en_ff;
    logic mst_en_ff;
    logic [1:0] sel_mode_ff;
    logic fault_ff;
    logic [2:0] ssel_sync_ff;
    wire ssel_s = ssel_sync_ff[1];
    wire ssel_fall = ssel_sync_ff[2] && !ssel_s;
    wire sel_hi = sel_mode_ff[SEL_MODE_HI_POS];
    wire sel_lo = sel_mode_ff[SEL_MODE_LO_POS];
    wire mode_3w = (sel_mode_ff == SEL_MODE_3WIRE);
    wire mode_4in = (sel_mode_ff == SEL_MODE_4WIRE_IN);
    wire is_master = port_en_ff && mst_en_ff;
    wire is_slave = port_en_ff && !mst_en_ff;
    wire fault_evt = is_master && mode_4in && ssel_fall;
    wire slv_sel = mode_3w || (mode_4in && !ssel_s);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ssel_sync_ff <= 3'h7;
        end else begin
            ssel_sync_ff <= {ssel_sync_ff[1:0], i_slave_select_n};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            port_en_ff <= 1'b0;
            mst_en_ff <= 1'b0;
            sel_mode_ff <= SEL_MODE_RESET;
            fault_ff <= 1'b0;
        end else begin
            if (fault_evt) begin
                port_en_ff <= 1'b0;
                mst_en_ff <= 1'b0;
            end else begin
                if (i_port_enable_set) port_en_ff <= 1'b1;
                else if (i_port_enable_clr) port_en_ff <= 1'b0;
                if (i_master_enable_set) mst_en_ff <= 1'b1;
                else if (i_master_enable_clr) mst_en_ff <= 1'b0;
            end
            if (i_select_mode_wr) sel_mode_ff <= i_select_mode_field;
            // Set wins over clear
            if (fault_evt) fault_ff <= 1'b1;
            else if (i_mode_fault_clr) fault_ff <= 1'b0;
        end
    end

    assign o_port_enable_bit = port_en_ff;
    assign o_master_enable_flag = mst_en_ff;
    assign o_select_mode_field = sel_mode_ff;
    assign o_mode_fault_flag = fault_ff;
    assign o_select_mapped = !mode_3w;

    //------------------------------------------------------------
    // Transmit buffer
    //------------------------------------------------------------
    logic fifo_valid;
    logic fifo_take;
    logic [DATA_W-1:0] fifo_data;

    spiprm_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_wr_valid(i_tx_valid),
        .o_wr_ready(o_tx_ready),
        .i_wr_data(i_tx_data),
        .o_rd_valid(fifo_valid),
        .i_rd_ready(fifo_take),
        .o_rd_data(fifo_data)
    );

    //------------------------------------------------------------
    // Master engine (system clock)
    //------------------------------------------------------------
    spiprm_mst_t mst_st_ff;
    logic [DATA_W-1:0] mst_sr_ff;
    logic [2:0] mst_bit_ff;
    logic [7:0] mst_div_ff;
    logic mst_rx_ff;
    logic [1:0] miso_sync_ff;
    wire div_done = (mst_div_ff == SCK_HALF_CNT);
    wire mst_start = is_master && (mst_st_ff == SPIPRM_IDLE) && fifo_valid;
    wire mst_last = (mst_st_ff == SPIPRM_HIGH) && div_done && (mst_bit_ff == BIT_CNT_LAST);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            miso_sync_ff <= 2'h0;
        end else begin
            miso_sync_ff <= {miso_sync_ff[0], i_miso};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst || !is_master) begin
            mst_st_ff <= SPIPRM_IDLE;
            mst_sr_ff <= '0;
            mst_bit_ff <= '0;
            mst_div_ff <= '0;
            mst_rx_ff <= 1'b0;
        end else begin
            mst_div_ff <= (mst_st_ff == SPIPRM_IDLE || div_done) ? 8'h00 : mst_div_ff + 8'h01;
            unique case (mst_st_ff)
                SPIPRM_IDLE: begin
                    if (mst_start) begin
                        mst_sr_ff <= fifo_data;
                        mst_bit_ff <= '0;
                        mst_st_ff <= SPIPRM_LOW;
                    end
                end
                SPIPRM_LOW: begin
                    if (div_done) begin
                        mst_rx_ff <= miso_sync_ff[1];
                        mst_st_ff <= SPIPRM_HIGH;
                    end
                end
                SPIPRM_HIGH: begin
                    if (div_done) begin
                        mst_sr_ff <= {mst_sr_ff[DATA_W-2:0], mst_rx_ff};
                        mst_bit_ff <= mst_bit_ff + 3'h1;
                        mst_st_ff <= mst_last ? SPIPRM_IDLE : SPIPRM_LOW;
                    end
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // Slave engine (link clock)
    //------------------------------------------------------------
    logic [1:0] rst_lnk_sync_ff;
    logic [2:0] slv_act_sync_ff;
    logic [DATA_W-1:0] slv_sr_ff;
    logic [DATA_W-1:0] slv_rx_ff;
    logic [3:0] slv_bit_ff;
    logic slv_done_tgl_ff;
    logic slv_ld_ack_tgl_ff;
    logic slv_ld_req_tgl_ff;
    logic [DATA_W-1:0] slv_ld_data_ff;
    logic [1:0] ld_req_sync_ff;
    wire rst_lnk = rst_lnk_sync_ff[1];
    wire slv_act_l = slv_act_sync_ff[2];
    wire slv_load_pend = ld_req_sync_ff[1] != slv_ld_ack_tgl_ff;

    // Reset and selection cross into the link domain
    always_ff @(posedge i_link_clk) begin
        rst_lnk_sync_ff <= {rst_lnk_sync_ff[0], i_rst};
        if (rst_lnk) begin
            slv_act_sync_ff <= 3'h0;
            ld_req_sync_ff <= 2'h0;
        end else begin
            // Third stage lets a pending byte load before selection
            slv_act_sync_ff <= {slv_act_sync_ff[1:0], is_slave && slv_sel};
            ld_req_sync_ff <= {ld_req_sync_ff[0], slv_ld_req_tgl_ff};
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (rst_lnk) begin
            slv_sr_ff <= '0;
            slv_rx_ff <= '0;
            slv_bit_ff <= BIT_CNT_RESET;
            slv_done_tgl_ff <= 1'b0;
            slv_ld_ack_tgl_ff <= 1'b0;
        end else if (!slv_act_l) begin
            slv_bit_ff <= BIT_CNT_RESET;
            if (slv_load_pend) begin
                slv_sr_ff <= slv_ld_data_ff;
                slv_ld_ack_tgl_ff <= ld_req_sync_ff[1];
            end
        end else begin
            slv_sr_ff <= {slv_sr_ff[DATA_W-2:0], i_mosi};
            if (slv_bit_ff[2:0] == BIT_CNT_LAST) begin
                slv_bit_ff <= BIT_CNT_RESET;
                slv_rx_ff <= {slv_sr_ff[DATA_W-2:0], i_mosi};
                slv_done_tgl_ff <= !slv_done_tgl_ff;
                if (slv_load_pend) begin
                    slv_sr_ff <= slv_ld_data_ff;
                    slv_ld_ack_tgl_ff <= ld_req_sync_ff[1];
                end
            end else begin
                slv_bit_ff <= slv_bit_ff + 4'h1;
            end
        end
    end

    // Slave load request and byte-done crossings
    logic [2:0] done_sync_ff;
    logic [1:0] ack_sync_ff;
    wire slv_idle_sys = (ack_sync_ff[1] == slv_ld_req_tgl_ff);
    wire slv_load_go = is_slave && fifo_valid && slv_idle_sys;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            done_sync_ff <= 3'h0;
            ack_sync_ff <= 2'h0;
            slv_ld_req_tgl_ff <= 1'b0;
            slv_ld_data_ff <= '0;
        end else begin
            done_sync_ff <= {done_sync_ff[1:0], slv_done_tgl_ff};
            ack_sync_ff <= {ack_sync_ff[0], slv_ld_ack_tgl_ff};
            if (slv_load_go) begin
                slv_ld_data_ff <= fifo_data;
                slv_ld_req_tgl_ff <= !slv_ld_req_tgl_ff;
            end
        end
    end

    assign fifo_take = mst_start || slv_load_go;

    //------------------------------------------------------------
    // Received byte
    //------------------------------------------------------------
    wire slv_done = done_sync_ff[2] != done_sync_ff[1];
    logic rx_valid_ff;
    logic [DATA_W-1:0] rx_data_ff;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rx_valid_ff <= 1'b0;
            rx_data_ff <= '0;
        end else begin
            rx_valid_ff <= mst_last || slv_done;
            if (mst_last) rx_data_ff <= {mst_sr_ff[DATA_W-2:0], mst_rx_ff};
            else if (slv_done) rx_data_ff <= slv_rx_ff;
        end
    end

    assign o_rx_valid = rx_valid_ff;
    assign o_rx_data = rx_data_ff;
    assign o_busy = (mst_st_ff != SPIPRM_IDLE);

    //------------------------------------------------------------
    // Pin roles
    //------------------------------------------------------------
    assign o_mosi = mst_sr_ff[DATA_W-1];
    assign o_mosi_oe_n = !is_master;
    assign o_miso = slv_sr_ff[DATA_W-1];
    assign o_miso_oe_n = !(is_slave && slv_sel);
    assign o_sck = (mst_st_ff == SPIPRM_HIGH);
    assign o_sck_oe_n = !is_master;
    assign o_slave_select_n = sel_lo;
    assign o_slave_select_oe_n = !(port_en_ff && sel_hi);
endmodule : spiprm_core

// File: core/spiprm_fifo.sv
`timescale 1ns/1ps
module spiprm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    wire do_wr = i_wr_valid && o_wr_ready;
    wire do_rd = o_rd_valid && i_rd_ready;

    assign o_wr_ready = (count_ff != (AW+1)'(DEPTH));
    assign o_rd_valid = (count_ff != '0);
    assign o_rd_data = mem[rd_ptr_ff];

    always_ff @(posedge i_sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr_ff] <= i_wr_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + AW'(do_wr);
            rd_ptr_ff <= rd_ptr_ff + AW'(do_rd);
            count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : spiprm_fifo

// File: pkg/spiprm_pkg.sv
package spiprm_pkg;
    // Select-mode field encodings
    localparam logic [1:0] SEL_MODE_3WIRE = 2'b00;
    localparam logic [1:0] SEL_MODE_4WIRE_IN = 2'b01;
    localparam logic [1:0] SEL_MODE_RESET = 2'b01;
    localparam int SEL_MODE_HI_POS = 1;
    localparam int SEL_MODE_LO_POS = 0;
    // Shift and buffer geometry
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    // Master serial clock divider: half period in system clocks
    localparam int SCK_HALF_CYC = 4;
    localparam logic [7:0] SCK_HALF_CNT = 8'(SCK_HALF_CYC - 1);
endpackage : spiprm_pkg

// File: verification/spiprm_core_monitor.sv
`timescale 1ns/1ps
module spiprm_core_monitor
    import spiprm_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic o_port_enable_bit,
    input wire logic o_master_enable_flag,
    input wire logic [1:0] o_select_mode_field,
    input wire logic o_mode_fault_flag,
    input wire logic o_select_mapped,
    input wire logic o_mosi_oe_n,
    input wire logic o_miso_oe_n,
    input wire logic o_sck,
    input wire logic o_sck_oe_n,
    input wire logic o_slave_select_n,
    input wire logic o_slave_select_oe_n
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // ----------------
    // Pin roles and select modes
    // ----------------
    wire logic mst = o_port_enable_bit && o_master_enable_flag;
    sequence s_master;
        mst [*2];
    endsequence
    sequence s_bit;
        o_sck [*4] ##1 !o_sck;
    endsequence
    sequence s_fault;
        $rose(o_mode_fault_flag);
    endsequence
    AST_MOSI_OUT: assert property (s_master |-> !o_mosi_oe_n && !o_sck_oe_n && o_miso_oe_n)
        else $error("master pin roles wrong");
    AST_MOSI_IN: assert property ((!o_master_enable_flag) [*2] |-> o_mosi_oe_n && o_sck_oe_n)
        else $error("slave pin roles wrong");
    AST_MISO_OFF: assert property ((!o_port_enable_bit) [*2] |-> o_miso_oe_n)
        else $error("miso driven while disabled");
    AST_MAP: assert property (o_select_mapped == (o_select_mode_field != SEL_MODE_3WIRE))
        else $error("select mapping wrong");
    AST_SEL_OUT: assert property ((o_port_enable_bit && o_select_mode_field[SEL_MODE_HI_POS]) [*2]
        ##0 $stable(o_select_mode_field) |-> !o_slave_select_oe_n
        && o_slave_select_n == o_select_mode_field[SEL_MODE_LO_POS])
        else $error("select output wrong");
    AST_SEL_IN: assert property ((!o_select_mode_field[SEL_MODE_HI_POS]) [*2] |-> o_slave_select_oe_n)
        else $error("select driven as input mode");
    AST_FAULT: assert property (s_fault |-> !o_port_enable_bit && !o_master_enable_flag)
        else $error("fault left enables set");
    AST_FAULT_SRC: assert property (s_fault |-> $past(o_master_enable_flag)
        && o_select_mode_field == SEL_MODE_4WIRE_IN)
        else $error("fault without cause");
    AST_RST: assert property ($fell(i_rst) |-> o_select_mode_field == SEL_MODE_RESET
        && !o_port_enable_bit && !o_mode_fault_flag)
        else $error("reset values wrong");
    AST_SCK_BIT: assert property ($rose(o_sck) |-> s_bit)
        else $error("sck high time wrong");
endmodule : spiprm_core_monitor

// File: verification/spiprm_core_test.sv
`timescale 1ns/1ps
module spiprm_core_test;
    import spiprm_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_port_enable_set = 1'b0, i_port_enable_clr = 1'b0;
    logic i_master_enable_set = 1'b0, i_master_enable_clr = 1'b0;
    logic i_select_mode_wr = 1'b0, i_mode_fault_clr = 1'b0, i_tx_valid = 1'b0;
    logic [1:0] i_select_mode_field = 2'h0;
    logic [7:0] i_tx_data = 8'h00, prev = 8'h00;
    logic o_port_enable_bit, o_master_enable_flag, o_mode_fault_flag, o_select_mapped;
    logic o_busy, o_tx_ready, o_rx_valid, o_mosi, o_mosi_oe_n, o_miso, o_miso_oe_n;
    logic o_sck, o_sck_oe_n, o_slave_select_n, o_slave_select_oe_n, p_mosi, p_miso, p_ssn;
    logic [1:0] o_select_mode_field;
    logic [7:0] o_rx_data;
    wire logic i_mosi, i_miso, i_slave_select_n, i_link_clk;
    wire logic [7:0] st = {o_select_mode_field, o_port_enable_bit, o_master_enable_flag,
        o_mode_fault_flag, o_mosi_oe_n, o_miso_oe_n, o_sck_oe_n};
    int fail_count = 0, tests_run = 0, cyc = 0, rx_cnt = 0;
    assign i_mosi = o_mosi_oe_n ? p_mosi : o_mosi;
    assign i_miso = o_miso_oe_n ? p_miso : o_miso;
    assign i_slave_select_n = o_slave_select_oe_n ? p_ssn : o_slave_select_n;
    spiprm_core u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
        .i_port_enable_set(i_port_enable_set), .i_port_enable_clr(i_port_enable_clr),
        .i_master_enable_set(i_master_enable_set), .i_master_enable_clr(i_master_enable_clr),
        .i_select_mode_wr(i_select_mode_wr), .i_select_mode_field(i_select_mode_field),
        .i_mode_fault_clr(i_mode_fault_clr), .o_port_enable_bit(o_port_enable_bit),
        .o_master_enable_flag(o_master_enable_flag), .o_select_mode_field(o_select_mode_field),
        .o_mode_fault_flag(o_mode_fault_flag), .o_select_mapped(o_select_mapped),
        .o_busy(o_busy), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
        .i_tx_data(i_tx_data), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
        .i_mosi(i_mosi), .o_mosi(o_mosi), .o_mosi_oe_n(o_mosi_oe_n), .i_miso(i_miso),
        .o_miso(o_miso), .o_miso_oe_n(o_miso_oe_n), .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n),
        .i_slave_select_n(i_slave_select_n), .o_slave_select_n(o_slave_select_n),
        .o_slave_select_oe_n(o_slave_select_oe_n));
    spiprm_peer u_peer (.i_sck(o_sck), .i_mosi(i_mosi), .i_miso(i_miso), .o_link_clk(i_link_clk),
        .o_mosi(p_mosi), .o_miso(p_miso), .o_slave_select_n(p_ssn));
    always #10 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) #2 if (o_rx_valid === 1'b1) rx_cnt++;
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    // ----------------
    // Shared tasks
    // ----------------
    task chk(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task cfg(input logic pe, me, input logic [1:0] m);
        @(posedge i_sys_clk);
        i_port_enable_set <= pe;
        i_port_enable_clr <= !pe;
        i_master_enable_set <= me;
        i_master_enable_clr <= !me;
        i_select_mode_wr <= 1'b1;
        i_select_mode_field <= m;
        @(posedge i_sys_clk);
        {i_port_enable_set, i_port_enable_clr, i_master_enable_set} <= 3'h0;
        {i_master_enable_clr, i_select_mode_wr} <= 2'h0;
        repeat (2) @(negedge i_sys_clk);
    endtask : cfg
    task put(input logic [7:0] b);
        @(posedge i_sys_clk);
        i_tx_valid <= 1'b1;
        i_tx_data <= b;
        do @(negedge i_sys_clk); while (o_tx_ready !== 1'b1);
        @(posedge i_sys_clk);
        i_tx_valid <= 1'b0;
    endtask : put
    task waitrx(input int n);
        repeat (2000) if (rx_cnt < n) @(negedge i_sys_clk);
    endtask : waitrx
    // ----------------
    // Scenarios
    // ----------------
    task mst(input logic [1:0] m);
        int n;
        int base;
        n = 0;
        cfg(1'b0, 1'b0, m);
        while (n < 9) begin
            @(negedge i_sys_clk);
            if (o_tx_ready !== 1'b1) break;
            put(8'h1D * 8'(n + 1));
            n++;
        end
        chk(8'(n), 8'(FIFO_DEPTH));
        base = rx_cnt;
        cfg(1'b1, 1'b1, m);
        chk(st, {m, 6'h32});
        chk({7'h0, o_busy}, 8'h01);
        chk({7'h0, o_select_mapped}, {7'h0, m != SEL_MODE_3WIRE});
        if (m[1]) chk({6'h0, o_slave_select_oe_n, o_slave_select_n}, {7'h0, m[0]});
        for (int k = 0; k < n; k++) begin
            waitrx(base + k + 1);
            chk(o_rx_data, prev);
            prev = 8'h1D * 8'(k + 1);
        end
        chk({7'h0, o_busy}, 8'h00);
        $display("master test done");
    endtask : mst
    task slv(input logic [1:0] m, input logic ssn, ok);
        logic [7:0] r;
        int base;
        cfg(1'b1, 1'b0, m);
        put(8'hC6);
        if (m == SEL_MODE_4WIRE_IN) u_peer.tick(5);
        u_peer.sel(ssn);
        repeat (8) @(posedge i_sys_clk);
        base = rx_cnt;
        u_peer.mx(8'h9B, r);
        repeat (8) @(posedge i_sys_clk);
        chk(8'(rx_cnt - base), {7'h0, ok});
        chk(st, {m, ok ? 6'h25 : 6'h27});
        if (ok) chk(o_rx_data, 8'h9B);
        if (ok) chk(r, 8'hC6);
        u_peer.sel(1'b1);
        $display("slave test done");
    endtask : slv
    task flt;
        cfg(1'b1, 1'b1, SEL_MODE_4WIRE_IN);
        u_peer.sel(1'b0);
        repeat (8) @(posedge i_sys_clk);
        chk(st, {SEL_MODE_4WIRE_IN, 6'h0F});
        u_peer.sel(1'b1);
        @(posedge i_sys_clk);
        i_mode_fault_clr <= 1'b1;
        @(posedge i_sys_clk);
        i_mode_fault_clr <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        chk(st, {SEL_MODE_4WIRE_IN, 6'h07});
        $display("fault test done");
    endtask : flt
    task end_sim;
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    initial begin
        fork
            u_peer.tick(6);
        join_none
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(negedge i_sys_clk);
        chk(st, {SEL_MODE_RESET, 6'h07});
        mst(SEL_MODE_3WIRE);
        mst(2'b10);
        slv(SEL_MODE_3WIRE, 1'b1, 1'b1);
        slv(SEL_MODE_4WIRE_IN, 1'b0, 1'b1);
        slv(SEL_MODE_4WIRE_IN, 1'b1, 1'b0);
        flt();
        end_sim();
    end
endmodule : spiprm_core_test
bind spiprm_core spiprm_core_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .o_port_enable_bit(o_port_enable_bit), .o_master_enable_flag(o_master_enable_flag),
    .o_select_mode_field(o_select_mode_field), .o_mode_fault_flag(o_mode_fault_flag),
    .o_select_mapped(o_select_mapped), .o_mosi_oe_n(o_mosi_oe_n), .o_miso_oe_n(o_miso_oe_n),
    .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n), .o_slave_select_n(o_slave_select_n),
    .o_slave_select_oe_n(o_slave_select_oe_n));

// File: verification/spiprm_peer.sv
`timescale 1ns/1ps
module spiprm_peer (
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_miso,
    output logic o_link_clk,
    output logic o_mosi,
    output logic o_miso,
    output logic o_slave_select_n
);
    // ----------------
    // Slave side echoes the previous byte
    // ----------------
    logic [7:0] sr = 8'h00;
    logic bit_in = 1'b0;
    initial begin
        o_link_clk = 1'b0;
        o_mosi = 1'b0;
        o_slave_select_n = 1'b1;
    end
    always @(posedge i_sck) bit_in <= i_mosi;
    always @(negedge i_sck) sr <= {sr[6:0], bit_in};
    assign o_miso = sr[7];
    // ----------------
    // Master side, link clock also ticks outside frames
    // ----------------
    task sel(input logic v);
        o_slave_select_n = v;
    endtask : sel
    task tick(input int n);
        repeat (n) begin
            #32 o_link_clk = 1'b1;
            #32 o_link_clk = 1'b0;
        end
    endtask : tick
    task mx(input logic [7:0] b, output logic [7:0] r);
        tick(3);
        for (int i = 7; i >= 0; i--) begin
            o_mosi = b[i];
            #32 r = {r[6:0], i_miso};
            o_link_clk = 1'b1;
            #32 o_link_clk = 1'b0;
        end
        o_mosi = ~o_mosi;
    endtask : mx
endmodule : spiprm_peer
